//--- rtl/bert_pkg.sv
package bert_pkg;

  // register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] CONTROL_OFS     = 4'h0;
  localparam logic [3:0] PATTERN_CFG_OFS = 4'h1;
  localparam logic [3:0] SEED_LOW_OFS    = 4'h2;
  localparam logic [3:0] SEED_HIGH_OFS   = 4'h3;
  localparam logic [3:0] STATUS_OFS      = 4'h4;
  localparam logic [3:0] BIT_CNT_LO_OFS  = 4'h5;
  localparam logic [3:0] BIT_CNT_HI_OFS  = 4'h6;
  localparam logic [3:0] ERR_CNT_LO_OFS  = 4'h7;
  localparam logic [3:0] ERR_CNT_HI_OFS  = 4'h8;

  // control register fields
  localparam int CTL_ENABLE      = 0;
  localparam int CTL_TX_LOAD     = 1;
  localparam int CTL_RX_LOAD     = 2;
  localparam int CTL_CNT_UPDATE  = 3;
  localparam int CTL_SINGLE_ERR  = 4;
  localparam int CTL_ERR_SRC_PIN = 5;
  localparam int CTL_RESYNC_DIS  = 6;
  localparam int CTL_TX_INVERT   = 7;
  localparam int CTL_RX_INVERT   = 8;
  localparam int CTL_RATE_LSB    = 9;
  localparam int CTL_RATE_W      = 3;

  // pattern configuration fields
  localparam int PCF_LEN_LSB = 0;
  localparam int PCF_REP     = 5;
  localparam int PCF_QRSS    = 6;
  localparam int PCF_TAP_LSB = 8;
  localparam int PCF_FIELD_W = 5;

  // status fields
  localparam int STS_ERR_PRESENT = 0;
  localparam int STS_OUT_OF_SYNC = 1;

  // reset values
  localparam logic [15:0] CONTROL_RST     = 16'h0000;
  localparam logic [15:0] PATTERN_CFG_RST = 16'h0000;
  localparam logic [15:0] SEED_RST        = 16'hffff;

  // checker figures
  localparam int SR_W         = 32;
  localparam int BIT_CNT_W    = 32;
  localparam int ERR_CNT_W    = 24;
  localparam int SYNC_BITS    = 32;
  localparam int WINDOW_BITS  = 64;
  localparam int RESYNC_ERRS  = 6;
  localparam int QRSS_ZERO_RUN = 14;
  localparam int QRSS_TAP_A   = 17;
  localparam int QRSS_TAP_B   = 20;
  localparam int RATE_MAX_EXP = 7;
  localparam int RATE_CNT_W   = 24;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_LOAD   = 5'b00010,
    RX_SEARCH = 5'b00100,
    RX_VERIFY = 5'b01000,
    RX_SYNC   = 5'b10000
  } rx_state_t;

endpackage : bert_pkg

//--- rtl/bit_error_rate_tester.sv
`timescale 1ns/1ns
`default_nettype none
module bit_error_rate_tester
  import bert_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [bert_pkg::ADDR_W-1:0] addr,
  input  wire logic [bert_pkg::DATA_W-1:0] wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [bert_pkg::DATA_W-1:0] rdata,
  input  wire logic                  tx_payload_en,
  output logic                       tx_data,
  input  wire logic                  rx_payload_en,
  input  wire logic                  rx_data_in,
  output logic                       rx_data_out,
  input  wire logic                  manual_error_insert_input,
  input  wire logic                  pm_update
);
  import bert_pkg::*;

  // mask of the low len+1 bits; len field holds n-1
  function automatic logic [SR_W-1:0] len_mask(input logic [PCF_FIELD_W-1:0] len);
    len_mask = {SR_W{1'b1}} >> (5'd31 - len);
  endfunction : len_mask

  // feedback of a generator from its current shift register
  function automatic logic gen_feedback(input logic [SR_W-1:0] sr, input logic [PCF_FIELD_W-1:0] len,
                                        input logic [PCF_FIELD_W-1:0] tap, input logic rep,
                                        input logic qrss);
    logic fb;
    fb = 1'b0;
    if (rep) begin
      fb = sr[len];
    end else if (qrss) begin
      fb = sr[QRSS_TAP_A-1] ^ sr[QRSS_TAP_B-1];
    end else begin
      fb = sr[len] ^ sr[tap];
    end
    if (!rep && sr[SR_W-2:0] == '0) begin
      fb = 1'b1; // lock-up guard
    end
    gen_feedback = fb;
  endfunction : gen_feedback

  // generator output: qrss forces a one after a run of zeros
  function automatic logic gen_output(input logic [SR_W-1:0] sr, input logic fb, input logic rep,
                                      input logic qrss);
    gen_output = (!rep && qrss && sr[QRSS_ZERO_RUN-1:0] == '0) ? 1'b1 : fb;
  endfunction : gen_output

  // 10^n - 1 for the error rate
  function automatic logic [RATE_CNT_W-1:0] rate_limit(input logic [CTL_RATE_W-1:0] n);
    logic [RATE_CNT_W-1:0] v;
    v = 24'h000001;
    for (int i = 1; i <= RATE_MAX_EXP; i++) begin
      if (i <= int'(n)) begin
        v = RATE_CNT_W'(v * 24'd10);
      end
    end
    rate_limit = v - 24'h000001;
  endfunction : rate_limit

  logic [DATA_W-1:0]    control_reg;
  logic [DATA_W-1:0]    pattern_config_reg;
  logic [DATA_W-1:0]    seed_low_reg;
  logic [DATA_W-1:0]    seed_high_reg;
  logic [BIT_CNT_W-1:0] rx_bit_count_reg;
  logic [ERR_CNT_W-1:0] rx_err_count_reg;
  logic [BIT_CNT_W-1:0] run_bits_reg;
  logic [ERR_CNT_W-1:0] run_errs_reg;
  logic [SR_W-1:0]      tx_sr_reg;
  logic [SR_W-1:0]      rx_sr_reg;
  logic                 tx_load_prev_reg;
  logic                 rx_load_prev_reg;
  logic                 tx_running_reg;
  logic [2:0]           pin_sync_reg;
  logic                 pin_level_reg;
  logic                 single_pend_reg;
  logic [RATE_CNT_W-1:0] rate_cnt_reg;
  logic [5:0]           phase_cnt_reg;
  logic [5:0]           win_cnt_reg;
  logic [2:0]           win_errs_reg;
  rx_state_t            rx_state_reg;
  rx_state_t            rx_state_next;

  logic                 tester_enable;
  logic [PCF_FIELD_W-1:0] len_f;
  logic [PCF_FIELD_W-1:0] tap_f;
  logic                 rep_f;
  logic                 qrss_f;
  logic [SR_W-1:0]      seed_masked;
  logic                 wr_ctl;
  logic                 tx_load_edge;
  logic                 rx_load_edge;
  logic                 cnt_update;
  logic                 pin_rise;
  logic                 single_req;
  logic                 tx_fb;
  logic                 tx_bit;
  logic                 rate_hit;
  logic                 rx_bit;
  logic                 rx_fb;
  logic                 rx_exp;
  logic                 rx_mismatch;
  logic                 rx_checking;
  logic                 win_lost;
  logic                 out_of_sync_flag;
  logic                 bit_error_present_flag;

  assign tester_enable = control_reg[CTL_ENABLE];
  assign len_f         = pattern_config_reg[PCF_LEN_LSB +: PCF_FIELD_W];
  assign tap_f         = pattern_config_reg[PCF_TAP_LSB +: PCF_FIELD_W];
  assign rep_f         = pattern_config_reg[PCF_REP];
  assign qrss_f        = pattern_config_reg[PCF_QRSS];
  assign seed_masked   = {seed_high_reg, seed_low_reg} & len_mask(len_f);
  assign wr_ctl        = wr && addr == CONTROL_OFS;

  // load bits act on their rising edge only while enabled
  assign tx_load_edge = wr_ctl && wdata[CTL_TX_LOAD] && !tx_load_prev_reg && wdata[CTL_ENABLE];
  assign rx_load_edge = wr_ctl && wdata[CTL_RX_LOAD] && !rx_load_prev_reg && wdata[CTL_ENABLE];
  assign cnt_update   = (wr_ctl && wdata[CTL_CNT_UPDATE]) || pm_update;

  // register writes; update and single-error bits are self-clearing strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg        <= CONTROL_RST;
      pattern_config_reg <= PATTERN_CFG_RST;
      seed_low_reg       <= SEED_RST;
      seed_high_reg      <= SEED_RST;
    end else if (wr) begin
      case (addr)
        CONTROL_OFS: begin
          control_reg                 <= wdata;
          control_reg[CTL_CNT_UPDATE] <= 1'b0;
          control_reg[CTL_SINGLE_ERR] <= 1'b0;
        end
        PATTERN_CFG_OFS: pattern_config_reg <= wdata;
        SEED_LOW_OFS:    seed_low_reg       <= wdata;
        SEED_HIGH_OFS:   seed_high_reg      <= wdata;
        default: ;
      endcase
    end
  end

  // previous value of the load bits for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_load_prev_reg <= 1'b0;
      rx_load_prev_reg <= 1'b0;
    end else if (wr_ctl) begin
      tx_load_prev_reg <= wdata[CTL_TX_LOAD];
      rx_load_prev_reg <= wdata[CTL_RX_LOAD];
    end
  end

  // read port, data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        CONTROL_OFS:     rdata <= control_reg;
        PATTERN_CFG_OFS: rdata <= pattern_config_reg;
        SEED_LOW_OFS:    rdata <= seed_low_reg;
        SEED_HIGH_OFS:   rdata <= seed_high_reg;
        STATUS_OFS:      rdata <= {14'h0000, out_of_sync_flag, bit_error_present_flag};
        BIT_CNT_LO_OFS:  rdata <= rx_bit_count_reg[15:0];
        BIT_CNT_HI_OFS:  rdata <= rx_bit_count_reg[31:16];
        ERR_CNT_LO_OFS:  rdata <= rx_err_count_reg[15:0];
        ERR_CNT_HI_OFS:  rdata <= {8'h00, rx_err_count_reg[23:16]};
        default:         rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // manual error pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_reg  <= 3'h0;
      pin_level_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], manual_error_insert_input};
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_level_reg <= pin_sync_reg[2];
      end
    end
  end

  assign pin_rise   = pin_sync_reg[1] && pin_sync_reg[2] && !pin_level_reg;
  assign single_req = control_reg[CTL_ERR_SRC_PIN] ? pin_rise
                                                   : (wr_ctl && wdata[CTL_SINGLE_ERR]);

  // one pending single error; a new request wins over the clear by use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      single_pend_reg <= 1'b0;
    end else if (single_req) begin
      single_pend_reg <= 1'b1;
    end else if (tx_payload_en && tx_running_reg) begin
      single_pend_reg <= 1'b0;
    end
  end

  // rate counter; rate field zero switches rate insertion off
  assign rate_hit = control_reg[CTL_RATE_LSB +: CTL_RATE_W] != 3'h0
                    && rate_cnt_reg >= rate_limit(control_reg[CTL_RATE_LSB +: CTL_RATE_W]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_reg <= '0;
    end else if (tx_load_edge || rate_hit && tx_payload_en && tx_running_reg) begin
      rate_cnt_reg <= '0;
    end else if (tx_payload_en && tx_running_reg) begin
      rate_cnt_reg <= rate_cnt_reg + 24'h000001;
    end
  end

  // transmit generator
  assign tx_fb  = gen_feedback(tx_sr_reg, len_f, tap_f, rep_f, qrss_f);
  assign tx_bit = gen_output(tx_sr_reg, tx_fb, rep_f, qrss_f) ^ single_pend_reg ^ rate_hit
                  ^ control_reg[CTL_TX_INVERT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sr_reg      <= '0;
      tx_running_reg <= 1'b0;
      tx_data        <= 1'b0;
    end else if (tx_load_edge) begin
      // the load write itself carries the enable, so it must win over the old disabled state
      tx_sr_reg      <= seed_masked; // preset before any output
      tx_running_reg <= 1'b1;
    end else if (!tester_enable) begin
      tx_running_reg <= 1'b0;
      tx_data        <= 1'b0;
    end else if (tx_payload_en && tx_running_reg) begin
      tx_sr_reg <= {tx_sr_reg[SR_W-2:0], tx_fb};
      tx_data   <= tx_bit;
    end
  end

  // receive side: stream passes straight on, checker taps payload bits only
  assign rx_data_out = rx_data_in;
  assign rx_bit      = rx_data_in ^ control_reg[CTL_RX_INVERT];
  assign rx_fb       = gen_feedback(rx_sr_reg, len_f, tap_f, rep_f, qrss_f);
  assign rx_exp      = gen_output(rx_sr_reg, rx_fb, rep_f, qrss_f);
  assign rx_mismatch = rx_bit != rx_exp;
  assign rx_checking = rx_payload_en && (rx_state_reg == RX_VERIFY || rx_state_reg == RX_SYNC);
  assign win_lost    = rx_state_reg == RX_SYNC && rx_payload_en
                       && (32'(win_errs_reg) + 32'(rx_mismatch)) >= RESYNC_ERRS
                       && !control_reg[CTL_RESYNC_DIS];

  // sync state machine
  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      RX_IDLE:   rx_state_next = RX_IDLE;
      RX_LOAD:   if (rx_payload_en && phase_cnt_reg == 6'(SYNC_BITS - 1)) rx_state_next = RX_VERIFY;
      RX_SEARCH: if (rx_payload_en && ({rx_sr_reg[SR_W-2:0], rx_bit} & len_mask(len_f)) == seed_masked)
                   rx_state_next = RX_VERIFY;
      RX_VERIFY: begin
        if (rx_payload_en && rx_mismatch) begin
          rx_state_next = rep_f ? RX_SEARCH : RX_LOAD;
        end else if (rx_payload_en && phase_cnt_reg == 6'(SYNC_BITS - 1)) begin
          rx_state_next = RX_SYNC;
        end
      end
      RX_SYNC:   if (win_lost) rx_state_next = rep_f ? RX_SEARCH : RX_LOAD;
      default:   rx_state_next = RX_IDLE;
    endcase
    if (rx_load_edge) begin
      rx_state_next = rep_f ? RX_SEARCH : RX_LOAD;
    end else if (!tester_enable) begin
      rx_state_next = RX_IDLE;
    end
  end

  // state, phase counter and receive shift register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg  <= RX_IDLE;
      phase_cnt_reg <= '0;
      rx_sr_reg     <= '0;
    end else begin
      rx_state_reg <= rx_state_next;
      if (rx_state_next != rx_state_reg) begin
        phase_cnt_reg <= '0;
      end else if (rx_payload_en) begin
        phase_cnt_reg <= phase_cnt_reg + 6'h01;
      end
      if (rx_payload_en) begin
        case (rx_state_reg)
          RX_LOAD, RX_SEARCH: rx_sr_reg <= {rx_sr_reg[SR_W-2:0], rx_bit}; // received bits seed it
          RX_VERIFY, RX_SYNC: rx_sr_reg <= {rx_sr_reg[SR_W-2:0], rx_fb};  // free running
          default: ;
        endcase
      end
    end
  end

  // 64-bit error window while in sync
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_reg  <= '0;
      win_errs_reg <= '0;
    end else if (rx_state_reg != RX_SYNC || win_lost) begin
      win_cnt_reg  <= '0;
      win_errs_reg <= '0;
    end else if (rx_payload_en) begin
      win_cnt_reg <= win_cnt_reg + 6'h01;
      if (win_cnt_reg == 6'(WINDOW_BITS - 1)) begin
        win_errs_reg <= '0;
      end else if (rx_mismatch && win_errs_reg != 3'h7) begin
        win_errs_reg <= win_errs_reg + 3'h1;
      end
    end
  end

  assign out_of_sync_flag = rx_state_reg != RX_SYNC;

  // running counters; the update copies them out and restarts from this bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_bits_reg     <= '0;
      run_errs_reg     <= '0;
      rx_bit_count_reg <= '0;
      rx_err_count_reg <= '0;
    end else begin
      if (cnt_update) begin
        rx_bit_count_reg <= run_bits_reg;
        rx_err_count_reg <= run_errs_reg;
        run_bits_reg     <= '0;
        run_errs_reg     <= '0;
      end
      if (rx_payload_en && !out_of_sync_flag) begin
        run_bits_reg <= (cnt_update ? '0 : run_bits_reg) + 32'h00000001;
        if (rx_mismatch) begin
          run_errs_reg <= (cnt_update ? '0 : run_errs_reg) + 24'h000001;
        end
      end
    end
  end

  assign bit_error_present_flag = rx_err_count_reg != '0;

endmodule : bit_error_rate_tester
`default_nettype wire

//--- tb/bit_error_rate_tester_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module bit_error_rate_tester_asserts
  import bert_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              tx_payload_en,
  input wire logic              tx_data,
  input wire logic              rx_payload_en,
  input wire logic              rx_data_in,
  input wire logic              rx_data_out,
  input wire logic              manual_error_insert_input,
  input wire logic              pm_update
);
  logic       ctl_wr;
  logic [6:0] rx_seen_reg;
  logic       rx_ld_reg;
  logic       tx_armed_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign ctl_wr = wr && addr == CONTROL_OFS;
  // rx bits since the last accepted rx load; no sync is possible before 33 of them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_seen_reg <= 7'h00;
    end else if (ctl_wr && wdata[CTL_ENABLE] && wdata[CTL_RX_LOAD] && !rx_ld_reg) begin
      rx_seen_reg <= 7'h00;
    end else if (rx_payload_en && rx_seen_reg != 7'h40) begin
      rx_seen_reg <= rx_seen_reg + 7'h01;
    end
  end
  // last written rx load bit, so only a zero-to-one counts as a load
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ld_reg <= 1'h0;
    end else if (ctl_wr) begin
      rx_ld_reg <= wdata[CTL_RX_LOAD];
    end
  end
  // tx may only carry data once enabled and loaded
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_armed_reg <= 1'h0;
    end else if (ctl_wr) begin
      tx_armed_reg <= wdata[CTL_ENABLE] && (tx_armed_reg || wdata[CTL_TX_LOAD]);
    end
  end
  sequence s_status_rd;
    rd && addr == STATUS_OFS;
  endsequence
  sequence s_early_status_rd;
    s_status_rd ##0 rx_seen_reg <= 7'h20;
  endsequence
  property p_passthru;
    rx_data_out == rx_data_in;
  endproperty
  property p_tx_hold;
    !tx_payload_en && !wr |=> $stable(tx_data);
  endproperty
  property p_tx_quiet;
    !tx_armed_reg |=> tx_data == 1'h0;
  endproperty
  property p_err_hi;
    rd && addr == ERR_CNT_HI_OFS |=> rdata[15:8] == 8'h00;
  endproperty
  property p_status_rsvd;
    s_status_rd |=> rdata[15:2] == 14'h0000;
  endproperty
  property p_sync_min;
    s_early_status_rd |=> rdata[STS_OUT_OF_SYNC];
  endproperty
  property p_ctl_strobe;
    rd && addr == CONTROL_OFS |=> rdata[CTL_SINGLE_ERR:CTL_CNT_UPDATE] == 2'h0;
  endproperty
  property p_unmapped;
    rd && addr > ERR_CNT_HI_OFS |=> rdata == 16'h0000;
  endproperty
  a_passthru: assert property (p_passthru)
    else $error("rx stream altered on its way through");
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx bit changed outside a payload slot");
  a_tx_quiet: assert property (p_tx_quiet)
    else $error("tx data without an enabled load");
  a_err_hi: assert property (p_err_hi)
    else $error("error count wider than 24 bits");
  a_status_rsvd: assert property (p_status_rsvd)
    else $error("status spare bits set");
  a_sync_min: assert property (p_sync_min)
    else $error("sync declared too early");
  a_ctl_strobe: assert property (p_ctl_strobe)
    else $error("strobe bits read back as one");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule : bit_error_rate_tester_asserts
bind bit_error_rate_tester bit_error_rate_tester_asserts i_asserts (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .tx_payload_en(tx_payload_en), .tx_data(tx_data), .rx_payload_en(rx_payload_en),
  .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
  .manual_error_insert_input(manual_error_insert_input), .pm_update(pm_update));
`default_nettype wire

//--- tb/framer_model.sv
`timescale 1ns/1ns
`default_nettype none
module framer_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic tx_data,
  output logic      tx_payload_en,
  output logic      rx_payload_en,
  output logic      rx_data_in
);
  logic phase_reg;
  logic filler_reg;
  // payload slot every other cycle, the gaps stand for overhead bits; tx loops back to rx
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg     <= 1'h0;
      tx_payload_en <= 1'h0;
      rx_payload_en <= 1'h0;
    end else begin
      phase_reg     <= ~phase_reg;
      tx_payload_en <= run && !phase_reg;
      rx_payload_en <= tx_payload_en;
    end
  end
  // outside payload slots the line toggles so a stale bit can never pass as valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filler_reg <= 1'h0;
    end else begin
      filler_reg <= ~filler_reg;
    end
  end
  assign rx_data_in = rx_payload_en ? tx_data : filler_reg;
endmodule : framer_model
`default_nettype wire

//--- tb/bit_error_rate_tester_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module bit_error_rate_tester_tb_top;
  import bert_pkg::*;
  logic              mclk, rst_n, wr, rd, pin, pm_update, run;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, ctl;
  logic              tx_payload_en, tx_data, rx_payload_en, rx_data_in, rx_data_out;
  int                err_count, checks;
  // cfg, seed high, seed low, extra control bits
  logic [63:0]       pat [8] = '{64'h0408_ffff_ffff_0080, 64'h0253_ffff_ffff_0000,
    64'h0d0e_ffff_ffff_0180, 64'h0020_ffff_fffe_0000, 64'h0020_ffff_ffff_0000,
    64'h0037_ff20_0022_0000, 64'h151f_ffff_ffff_0000, 64'h0408_ffff_ffff_0000};

  always #50 mclk = ~mclk;

  bit_error_rate_tester i_bit_error_rate_tester (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_payload_en(tx_payload_en),
    .tx_data(tx_data), .rx_payload_en(rx_payload_en), .rx_data_in(rx_data_in),
    .rx_data_out(rx_data_out), .manual_error_insert_input(pin), .pm_update(pm_update));
  framer_model i_framer_model (.mclk(mclk), .rst_n(rst_n), .run(run), .tx_data(tx_data),
    .tx_payload_en(tx_payload_en), .rx_payload_en(rx_payload_en), .rx_data_in(rx_data_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // strobe dropped one edge before return, so back-to-back calls never double-drive it
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    cyc(1);
    wr <= 1'h0;
    cyc(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr <= a;
    rd <= 1'h1;
    cyc(1);
    rd <= 1'h0;
    @(negedge mclk);
    d = rdata;
    cyc(1);
  endtask : rd_reg
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string what);
    logic [DATA_W-1:0] v;
    rd_reg(a, v);
    chk({16'h0000, v}, {16'h0000, e}, what);
  endtask : rd_chk
  task automatic cnt_chk(input logic [31:0] bits, input logic [23:0] errs);
    logic [DATA_W-1:0] lo, hi;
    rd_reg(BIT_CNT_LO_OFS, lo);
    rd_reg(BIT_CNT_HI_OFS, hi);
    chk({hi, lo}, bits, "bit count");
    rd_reg(ERR_CNT_LO_OFS, lo);
    rd_reg(ERR_CNT_HI_OFS, hi);
    chk({hi, lo}, {8'h00, errs}, "error count");
  endtask : cnt_chk
  // exactly n payload bits, then a quiet tail so the last rx bit lands
  task automatic send(input int n);
    run <= 1'h1;
    cyc(2 * n);
    run <= 1'h0;
    cyc(4);
  endtask : send
  task automatic update(input logic by_pin);
    if (by_pin) begin
      pm_update <= 1'h1;
      cyc(1);
      pm_update <= 1'h0;
      cyc(1);
    end else begin
      wr_reg(CONTROL_OFS, ctl | 16'h0008);
    end
  endtask : update
  task automatic load(input logic [DATA_W-1:0] c);
    ctl = c;
    wr_reg(CONTROL_OFS, ctl);
    ctl = c | 16'h0006;
    wr_reg(CONTROL_OFS, ctl);
  endtask : load
  task automatic pulse_pin();
    pin <= 1'h1;
    cyc(8);
    pin <= 1'h0;
    cyc(4);
  endtask : pulse_pin
  task automatic t_reset();
    rd_chk(CONTROL_OFS, CONTROL_RST, "control");
    rd_chk(PATTERN_CFG_OFS, PATTERN_CFG_RST, "pattern cfg");
    rd_chk(SEED_LOW_OFS, SEED_RST, "seed low");
    rd_chk(SEED_HIGH_OFS, SEED_RST, "seed high");
    wr_reg(STATUS_OFS, 16'hffff);
    rd_chk(STATUS_OFS, 16'h0002, "status");
    rd_chk(4'hf, 16'h0000, "unmapped");
    cnt_chk(32'h0, 24'h0);
  endtask : t_reset
  task automatic t_off_load();
    wr_reg(CONTROL_OFS, 16'h0006);
    send(40);
    chk({31'h0, tx_data}, 32'h0, "tx while off");
    rd_chk(STATUS_OFS, 16'h0002, "status while off");
    wr_reg(CONTROL_OFS, 16'h0000);
  endtask : t_off_load
  task automatic t_patterns();
    foreach (pat[i]) begin
      wr_reg(PATTERN_CFG_OFS, pat[i][63:48]);
      wr_reg(SEED_HIGH_OFS, pat[i][47:32]);
      wr_reg(SEED_LOW_OFS, pat[i][31:16]);
      load(16'h0001 | pat[i][15:0]);
      send(200);
      // tx inversion alone must keep the checker out of sync
      rd_chk(STATUS_OFS, (pat[i][8:7] == 2'b01) ? 16'h0002 : 16'h0000, "sync");
      if (pat[i][63:48] == 16'h0020) begin
        chk({31'h0, tx_data}, {31'h0, pat[i][16]}, "repeated bit");
      end
    end
  endtask : t_patterns
  task automatic t_counts();
    update(1'h0);
    send(50);
    update(1'h1);
    cnt_chk(32'h32, 24'h0);
    wr_reg(CONTROL_OFS, ctl | 16'h0010);
    send(20);
    update(1'h1);
    cnt_chk(32'h14, 24'h1);
    rd_chk(STATUS_OFS, 16'h0001, "error flag");
    update(1'h0);
    rd_chk(STATUS_OFS, 16'h0000, "error flag clear");
  endtask : t_counts
  task automatic t_pin();
    pulse_pin();
    send(20);
    ctl = ctl | 16'h0020;
    wr_reg(CONTROL_OFS, ctl);
    pulse_pin();
    send(20);
    update(1'h1);
    cnt_chk(32'h28, 24'h1);
  endtask : t_pin
  task automatic t_rate();
    ctl = ctl | 16'h0240;
    wr_reg(CONTROL_OFS, ctl);
    update(1'h0);
    send(100);
    update(1'h1);
    cnt_chk(32'h64, 24'ha);
    rd_chk(STATUS_OFS, 16'h0001, "sync held");
    ctl = ctl & 16'hffbf;
    wr_reg(CONTROL_OFS, ctl);
    send(150);
    update(1'h0);
    send(50);
    update(1'h1);
    cnt_chk(32'h0, 24'h0);
    rd_chk(STATUS_OFS, 16'h0002, "sync lost");
    ctl = ctl & 16'hf1ff;
    wr_reg(CONTROL_OFS, ctl);
    send(100);
    rd_chk(STATUS_OFS, 16'h0000, "resynced");
  endtask : t_rate
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'h0;
    rd = 1'h0;
    pin = 1'h0;
    pm_update = 1'h0;
    run = 1'h0;
    ctl = 16'h0000;
    err_count = 0;
    checks = 0;
    cyc(16);
    rst_n <= 1'h1;
    cyc(2);
    t_reset();
    t_off_load();
    t_patterns();
    t_counts();
    t_pin();
    t_rate();
    give_verdict();
  end
endmodule : bit_error_rate_tester_tb_top
`default_nettype wire
